//--- inc/atc_pkg.sv
// Constants, register map and carrier types of the threshold-compare converter controller.
// Assumes a single 200 MHz clock and a word-indexed register port.
package atc_pkg;

  // ==========================================================================
  // Widths and timing
  localparam int unsigned ATC_RES_W       = 10;   // Conversion result width
  localparam int unsigned ATC_NUM_CH      = 24;   // Analog input channels
  localparam int unsigned ATC_CH_W        = 5;    // Channel index width
  localparam int unsigned ATC_ADDR_W      = 8;    // Register index width
  localparam int unsigned ATC_DATA_W      = 32;   // Register data width
  localparam int unsigned ATC_CNT_W       = 16;   // Conversion cycle counter width
  localparam int unsigned ATC_CLK_NS      = 5;    // Clock period
  localparam int unsigned ATC_CONV_NS     = 1000; // Conversion time, plain default
  localparam int unsigned ATC_CONV_CYCLES = (ATC_CONV_NS + ATC_CLK_NS - 1) / ATC_CLK_NS;

  // ==========================================================================
  // Register indices
  localparam logic [7:0] ATC_REG_MODE0   = 8'h00; // converter_mode_reg0
  localparam logic [7:0] ATC_REG_CHSEL   = 8'h01; // channel_select_reg
  localparam logic [7:0] ATC_REG_PFMODE  = 8'h02; // pf_compare_mode_reg
  localparam logic [7:0] ATC_REG_PFTHR   = 8'h03; // pf_threshold_reg
  localparam logic [7:0] ATC_REG_STATUS  = 8'h04; // conversion_irq_flag, write 1 clears
  localparam logic [7:0] ATC_REG_RESBASE = 8'h10; // channel_result_reg 0 onward

  // ==========================================================================
  // Field positions
  localparam int unsigned ATC_M0_CE   = 0; // convert_enable
  localparam int unsigned ATC_M0_PS   = 1; // converter_power
  localparam int unsigned ATC_M0_MD   = 2; // Mode, two bits
  localparam int unsigned ATC_M0_HW   = 4; // Hardware trigger mode
  localparam int unsigned ATC_M0_BUSY = 5; // Conversion in progress, read only
  localparam int unsigned ATC_PF_EN   = 0; // pf_compare_enable
  localparam int unsigned ATC_PF_COND = 1; // pf_condition_select
  localparam int unsigned ATC_ST_FLAG = 0; // conversion_irq_flag

  // ==========================================================================
  // Modes: bit 0 is scan, bit 1 is one-shot
  typedef enum logic [1:0] {
    ATC_MD_CONT_SEL = 2'h0,
    ATC_MD_CONT_SCN = 2'h1,
    ATC_MD_ONE_SEL  = 2'h2,
    ATC_MD_ONE_SCN  = 2'h3
  } atc_mode_e;

  // Sequencer states, Gray along idle, convert, wait
  typedef enum logic [1:0] {
    ATC_ST_IDLE = 2'b00,
    ATC_ST_CONV = 2'b01,
    ATC_ST_WAIT = 2'b11
  } atc_state_e;

  // Register port carrier
  typedef struct packed {
    logic [ATC_ADDR_W-1:0] addr;
    logic [ATC_DATA_W-1:0] wdata;
    logic                  we;
    logic                  re;
  } atc_bus_s;

  // Reset values
  localparam logic [ATC_CH_W-1:0]  ATC_CHSEL_RST = 5'h00;
  localparam logic [ATC_RES_W-1:0] ATC_THR_RST   = 10'h000;

endpackage : atc_pkg

//--- design/atc_ctrl.sv
// Sequencer, threshold compare and register file of the converter controller.
// Assumes the analog front end presents a stable result for adc_channel
// at the end of each conversion window, on the same clock.
`timescale 1ns/1ps

module atc_ctrl
  import atc_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = ATC_CONV_CYCLES // Cycles per conversion
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire atc_bus_s              bus,
  output logic [ATC_DATA_W-1:0]      reg_rdata,
  input  wire logic [ATC_RES_W-1:0]  adc_data,
  input  wire logic                  hw_trigger,
  output logic [ATC_CH_W-1:0]        adc_channel,
  output logic                       adc_sampling,
  output logic                       conversion_end_irq,
  output logic                       conversion_irq_flag,
  output logic                       power_down
);

  // ==========================================================================
  // State
  // All stored state sits in this one record.
  // Next-state logic reads s_q and writes s_d only.
  // Results are flops, not a memory macro:
  // any channel can be read while another is stored.
  // Settings change only by register writes,
  // except ce, which one-shot modes drop.
  // The result array dominates the flop count.
  typedef struct packed {
    atc_state_e                           st;       // Sequencer state
    logic                                 ce;       // convert_enable
    logic                                 ps;       // converter_power
    atc_mode_e                            md;       // Operating mode
    logic                                 hw;       // Hardware trigger mode
    logic [ATC_CH_W-1:0]                  chsel;    // Last channel or selected one
    logic                                 pf_en;    // Compare enable
    logic                                 pf_cond;  // 0 equal, 1 less than
    logic [ATC_RES_W-1:0]                 thr;      // Threshold
    logic                                 flag;     // Sticky completion flag
    logic                                 irq;      // One-cycle interrupt pulse
    logic                                 hit;      // Channel 0 verdict of this scan
    logic [ATC_CH_W-1:0]                  cur;      // Channel being converted
    logic [ATC_CNT_W-1:0]                 cnt;      // Cycles into conversion
    logic [ATC_NUM_CH-1:0][ATC_RES_W-1:0] res;      // Result registers
    logic [ATC_DATA_W-1:0]                rdata;    // Read data, one cycle after strobe
    logic                                 trg_s1;   // Trigger synchroniser, first stage
    logic                                 trg_s2;   // Trigger synchroniser, second stage
    logic                                 trg_s3;   // Edge detector history
  } atc_state_s;

  // Counter end point and highest channel, sized to their fields.
  // CONV_CYCLES must be at least 1 and fit the counter.
  // A longer window changes no other timing.
  localparam logic [ATC_CNT_W-1:0] CNT_LAST = ATC_CNT_W'(CONV_CYCLES - 1);
  localparam logic [ATC_CH_W-1:0]  CH_MAX   = ATC_CH_W'(ATC_NUM_CH - 1);

  atc_state_s s_q;
  atc_state_s s_d;

  // Combinational helpers of the next-state process.
  // None is stored; each is recomputed every cycle.
  // wr_ch is the raw low bits; saturation is at the write.
  logic                  cfg_wr;   // Write to mode, select or compare registers
  logic                  trg_edge; // Accepted rising edge of the trigger
  logic                  cmp;      // Compare verdict of the present result
  logic                  scan;     // Scan mode
  logic                  last;     // Present channel ends the sequence
  logic                  verdict;  // Interrupt decision for this completion
  logic [ATC_CH_W-1:0]   wr_ch;    // Raw channel select write value, clamped at the write
  logic [ATC_ADDR_W-1:0] res_idx;  // Result index of a read address

  // ==========================================================================
  // Next state
  // All decisions live here so one always_ff registers the whole copy.
  // Writes are applied first, then the sequencer sees the new copy,
  // so a write and a completion in one cycle meet in one place.
  // The read mux looks only at s_q: a read shows pre-write values.
  // Helpers get values at the top, so no path leaves them open.
  // s_d starts as a copy of s_q, so untouched fields hold.
  // The interrupt pulse and read data default to zero each cycle.
  // Nothing here depends on the order of the case items.
  always_comb begin
    s_d      = s_q;
    s_d.irq  = 1'b0;
    s_d.rdata = '0;
    cfg_wr   = bus.we && (bus.addr <= ATC_REG_PFTHR);
    trg_edge = s_q.trg_s2 && !s_q.trg_s3;
    wr_ch    = bus.wdata[ATC_CH_W-1:0];
    res_idx  = bus.addr - ATC_REG_RESBASE;
    cmp      = 1'b0;
    scan     = 1'b0;
    last     = 1'b0;
    verdict  = 1'b0;

    // The trigger pin is asynchronous: two stages settle it,
    // a third keeps the last settled level for edge detection.
    // An edge acts only in WAIT or a hardware-mode conversion.
    // Synchroniser: the first stage feeds only the second
    s_d.trg_s1 = hw_trigger;
    s_d.trg_s2 = s_q.trg_s1;
    s_d.trg_s3 = s_q.trg_s2;

    // Mode, select and compare writes are also configuration
    // writes for the sequencer below.
    // Result registers are read only; writes to them are lost.
    // Register writes
    if (bus.we) begin
      if (bus.addr == ATC_REG_MODE0) begin
        s_d.ce = bus.wdata[ATC_M0_CE];
        s_d.ps = bus.wdata[ATC_M0_PS];
        s_d.md = atc_mode_e'(bus.wdata[ATC_M0_MD +: 2]);
        s_d.hw = bus.wdata[ATC_M0_HW];
      end else if (bus.addr == ATC_REG_CHSEL) begin
        // Flag left untouched here on purpose
        s_d.chsel = (wr_ch > CH_MAX) ? CH_MAX : wr_ch;
      end else if (bus.addr == ATC_REG_PFMODE) begin
        s_d.pf_en   = bus.wdata[ATC_PF_EN];
        s_d.pf_cond = bus.wdata[ATC_PF_COND];
      end else if (bus.addr == ATC_REG_PFTHR) begin
        s_d.thr = bus.wdata[ATC_RES_W-1:0];
      end else if (bus.addr == ATC_REG_STATUS) begin
        // Write one clears; a completion below in the same cycle wins
        if (bus.wdata[ATC_ST_FLAG]) begin
          s_d.flag = 1'b0;
        end
      end
    end

    // Compare path: the verdict uses the live front-end data,
    // the very value stored at the same edge.
    // Using the stored copy would cost a cycle and let a
    // threshold write slip in between.
    scan = s_d.md[0];
    // Unsigned, equal width, decided as the result is stored
    if (s_d.pf_cond) begin
      cmp = (adc_data < s_d.thr);
    end else begin
      cmp = (adc_data == s_d.thr);
    end
    // A select sequence is one channel long; a scan ends when
    // the channel just converted reaches the saturated pick.
    last = !scan || (s_q.cur >= s_d.chsel);

    // IDLE waits for enable, WAIT for a hardware trigger,
    // CONV counts one window per channel.
    // CONV priority: enable cleared, configuration write,
    // trigger, completion.
    // A completion beside a configuration write is dropped:
    // the write has already made the sample suspect.
    // In scans the channel 0 verdict waits in hit until the end.
    // Sequencer
    case (s_q.st)
      ATC_ST_IDLE: begin
        if (s_d.ce) begin
          if (s_d.hw) begin
            s_d.st = ATC_ST_WAIT;
          end else begin
            // Setting the enable bit starts at once
            s_d.st  = ATC_ST_CONV;
            s_d.cnt = '0;
            s_d.cur = scan ? '0 : s_d.chsel;
          end
        end
      end
      ATC_ST_WAIT: begin
        if (!s_d.ce) begin
          s_d.st = ATC_ST_IDLE;
        end else if (!s_d.hw) begin
          // Switched to software trigger: start at once
          s_d.st  = ATC_ST_CONV;
          s_d.cnt = '0;
          s_d.cur = scan ? '0 : s_d.chsel;
        end else if (trg_edge) begin
          // Results may be spoilt from here on
          s_d.st  = ATC_ST_CONV;
          s_d.cnt = '0;
          s_d.cur = scan ? '0 : s_d.chsel;
        end
      end
      ATC_ST_CONV: begin
        if (!s_d.ce) begin
          // Enable cleared: stop, no result stored
          s_d.st = ATC_ST_IDLE;
        end else if (cfg_wr && !s_d.hw) begin
          // Abort and restart from the beginning
          s_d.cnt = '0;
          s_d.cur = scan ? '0 : s_d.chsel;
        end else if (cfg_wr) begin
          // Hardware trigger mode goes back to waiting
          s_d.st = ATC_ST_WAIT;
        end else if (trg_edge && s_d.hw) begin
          // Trigger during conversion restarts it
          s_d.cnt = '0;
          s_d.cur = scan ? '0 : s_d.chsel;
        end else if (s_q.cnt >= CNT_LAST) begin
          // Stored whatever the verdict
          s_d.res[s_q.cur] = adc_data;
          if (scan && (s_q.cur == '0)) begin
            s_d.hit = cmp;
          end
          if (!s_d.pf_en) begin
            verdict = 1'b1;
          end else if (scan) begin
            verdict = (s_q.cur == '0) ? cmp : s_q.hit;
          end else begin
            verdict = cmp;
          end
          if (last) begin
            s_d.irq = verdict;
            if (verdict) begin
              s_d.flag = 1'b1;
            end
            if (s_d.md[1]) begin
              // One-shot: stop and drop the enable bit
              s_d.st = ATC_ST_IDLE;
              s_d.ce = 1'b0;
            end else if (s_d.hw) begin
              s_d.st = ATC_ST_WAIT;
            end else begin
              // Continuous: go again while enabled
              s_d.cnt = '0;
              s_d.cur = scan ? '0 : s_d.chsel;
            end
          end else begin
            // Next channel of the scan
            s_d.cnt = '0;
            s_d.cur = s_q.cur + 1'b1;
          end
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      default: begin
        s_d.st = ATC_ST_IDLE;
      end
    endcase

    // Read data is registered: it stands in the cycle after the
    // strobe only, then returns to zero.
    // Narrow fields read as zero in the upper bits.
    // Read data, decoded on the old state so the answer shows pre-write values
    if (bus.re) begin
      if (bus.addr == ATC_REG_MODE0) begin
        s_d.rdata[ATC_M0_CE]      = s_q.ce;
        s_d.rdata[ATC_M0_PS]      = s_q.ps;
        s_d.rdata[ATC_M0_MD +: 2] = s_q.md;
        s_d.rdata[ATC_M0_HW]      = s_q.hw;
        s_d.rdata[ATC_M0_BUSY]    = (s_q.st == ATC_ST_CONV);
      end else if (bus.addr == ATC_REG_CHSEL) begin
        s_d.rdata[ATC_CH_W-1:0] = s_q.chsel;
      end else if (bus.addr == ATC_REG_PFMODE) begin
        s_d.rdata[ATC_PF_EN]   = s_q.pf_en;
        s_d.rdata[ATC_PF_COND] = s_q.pf_cond;
      end else if (bus.addr == ATC_REG_PFTHR) begin
        s_d.rdata[ATC_RES_W-1:0] = s_q.thr;
      end else if (bus.addr == ATC_REG_STATUS) begin
        s_d.rdata[ATC_ST_FLAG] = s_q.flag;
      end else if ((bus.addr >= ATC_REG_RESBASE) && (res_idx < ATC_ADDR_W'(ATC_NUM_CH))) begin
        s_d.rdata[ATC_RES_W-1:0] = s_q.res[res_idx[ATC_CH_W-1:0]];
      end
      // Unmapped addresses read as zero
    end
  end

  // ==========================================================================
  // State register
  // The asynchronous reset loads constants only.
  // Field-wise lines after the clear name the reset values,
  // even where they happen to be zero.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q       <= '0;
      s_q.st    <= ATC_ST_IDLE;
      s_q.md    <= ATC_MD_CONT_SEL;
      s_q.chsel <= ATC_CHSEL_RST;
      s_q.thr   <= ATC_THR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  // Each output is a flop or a small decode of flops;
  // nothing from the bus reaches a pin combinationally.
  // The interrupt is one cycle; the flag holds until cleared.
  // adc_channel changes only at a window boundary.
  // power_down decodes the two stored bits, not the bus.
  assign reg_rdata           = s_q.rdata;
  assign adc_channel         = s_q.cur;
  assign adc_sampling        = (s_q.st == ATC_ST_CONV);
  assign conversion_end_irq  = s_q.irq;
  assign conversion_irq_flag = s_q.flag;
  // Both bits clear puts the converter to sleep
  assign power_down          = !s_q.ce && !s_q.ps;

endmodule // atc_ctrl

//--- verification/atc_ctrl_sva.sv
// Port checker for the converter controller.
// Assumes the atc_pkg register map; bound into atc_ctrl below.
`timescale 1ns/1ps
module atc_ctrl_sva
  import atc_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = ATC_CONV_CYCLES // Cycles per conversion
) (
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire atc_bus_s             bus,
  input wire logic [ATC_DATA_W-1:0] reg_rdata,
  input wire logic [ATC_RES_W-1:0] adc_data,
  input wire logic                 hw_trigger,
  input wire logic [ATC_CH_W-1:0]  adc_channel,
  input wire logic                 adc_sampling,
  input wire logic                 conversion_end_irq,
  input wire logic                 conversion_irq_flag,
  input wire logic                 power_down
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // Shadows of software settings, rebuilt from bus writes alone
  logic [4:0]          mode_q;   // Last mode word with trigger bit; ce may auto-clear
  logic [ATC_CH_W-1:0] chsel_q;  // Last channel pick, saturated
  logic                mwr;      // Mode word write
  logic                clr_q;    // Flag clear written in the last cycle
  logic                pd_exp_q; // Power-down level asked by the last mode write
  assign mwr = bus.we && bus.addr == ATC_REG_MODE0;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q   <= '0;
      chsel_q  <= '0;
      clr_q    <= 1'b0;
      pd_exp_q <= 1'b1;
    end else begin
      clr_q <= bus.we && bus.addr == ATC_REG_STATUS && bus.wdata[ATC_ST_FLAG];
      if (mwr) mode_q <= bus.wdata[4:0];
      if (mwr) pd_exp_q <= !(bus.wdata[ATC_M0_CE] || bus.wdata[ATC_M0_PS]);
      if (bus.we && bus.addr == ATC_REG_CHSEL)
        chsel_q <= (bus.wdata[4:0] > 5'h17) ? 5'h17 : bus.wdata[4:0];
    end
  end
  // ==========================================================================
  // Properties
  property p_irq_flag; conversion_end_irq |-> conversion_irq_flag; endproperty
  a_irq_flag: assert property (p_irq_flag) else $error("irq without flag");
  property p_irq_pulse; conversion_end_irq |-> $past(adc_sampling) ##1 !conversion_end_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq not a lone pulse");
  property p_start; mwr && bus.wdata[ATC_M0_CE] && !bus.wdata[ATC_M0_HW] |=> adc_sampling;
  endproperty
  a_start: assert property (p_start) else $error("enable did not start");
  property p_restart;
    bus.we && bus.addr <= ATC_REG_PFTHR && adc_sampling |=> !conversion_end_irq [*3];
  endproperty
  a_restart: assert property (p_restart) else $error("config write did not restart");
  property p_chsel_keep;
    bus.we && bus.addr == ATC_REG_CHSEL && conversion_irq_flag |=> conversion_irq_flag;
  endproperty
  a_chsel_keep: assert property (p_chsel_keep) else $error("chsel cleared flag");
  property p_flag_clear;
    $fell(conversion_irq_flag) |-> clr_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag fell by itself");
  property p_pd;
    mwr |=> power_down == pd_exp_q;
  endproperty
  a_pd: assert property (p_pd) else $error("power down level wrong");
  property p_oneshot; conversion_end_irq && mode_q[3] |=> !adc_sampling [*3]; endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot kept converting");
  property p_cont;
    conversion_end_irq && mode_q[4:2] == 3'b000 && mode_q[0]
      |-> ##[0:1] (adc_sampling && adc_channel == chsel_q);
  endproperty
  a_cont: assert property (p_cont) else $error("continuous select stalled");
  c_scan_irq: cover property (conversion_end_irq && mode_q[2]);
  c_chsel_flag: cover property (bus.we && bus.addr == ATC_REG_CHSEL && conversion_irq_flag);
  c_pd_rise: cover property ($rose(power_down));
endmodule // atc_ctrl_sva

bind atc_ctrl atc_ctrl_sva #(.CONV_CYCLES(CONV_CYCLES)) i_sva (
  .clk(clk), .sys_rst(sys_rst), .bus(bus), .reg_rdata(reg_rdata), .adc_data(adc_data),
  .hw_trigger(hw_trigger), .adc_channel(adc_channel), .adc_sampling(adc_sampling),
  .conversion_end_irq(conversion_end_irq), .conversion_irq_flag(conversion_irq_flag),
  .power_down(power_down));

//--- verification/atc_front_model.sv
// Analog front end model: one held level per input channel.
// Assumes the bench loads level_q by hierarchy before each conversion.
`timescale 1ns/1ps
module atc_front_model
  import atc_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic [ATC_CH_W-1:0]  adc_channel,
  input  wire logic                 adc_sampling,
  output logic      [ATC_RES_W-1:0] adc_data
);
  logic [ATC_RES_W-1:0] level_q [ATC_NUM_CH]; // Level on each pin
  logic [ATC_RES_W-1:0] junk_q;               // Off-window pattern
  initial begin
    foreach (level_q[i]) level_q[i] = '0;
    junk_q = 10'h155;
  end
  // Junk changes every cycle, so a sample taken late never looks right
  always @(posedge clk) begin
    junk_q <= ~junk_q + 10'h001;
  end
  always_comb begin
    adc_data = adc_sampling ? level_q[adc_channel] : junk_q;
  end
endmodule // atc_front_model

//--- verification/atc_ctrl_tb.sv
// Self-checking bench for the converter controller.
// Assumes atc_pkg, the front end model and the bound checker.
`timescale 1ns/1ps
module atc_ctrl_tb
  import atc_pkg::*;
();
  localparam int unsigned N = 4; // Short conversion keeps the run brief
  logic clk, sys_rst, irq, flag, power_down, adc_sampling, trig;
  atc_bus_s              bus;
  logic [ATC_DATA_W-1:0] reg_rdata;
  logic [ATC_RES_W-1:0]  adc_data;
  logic [ATC_CH_W-1:0]   adc_channel;
  int                    err_total, n_checks;
  atc_ctrl #(.CONV_CYCLES(N)) i_dut (.clk(clk), .sys_rst(sys_rst), .bus(bus),
    .reg_rdata(reg_rdata), .adc_data(adc_data), .hw_trigger(trig),
    .adc_channel(adc_channel), .adc_sampling(adc_sampling), .conversion_end_irq(irq),
    .conversion_irq_flag(flag), .power_down(power_down));
  atc_front_model i_front (.clk(clk), .adc_channel(adc_channel),
    .adc_sampling(adc_sampling), .adc_data(adc_data));
  always #2.5 clk = ~clk;
  // ==========================================================================
  // Bus tasks and checks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk);
    bus.we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: '0, we: 1'b0, re: 1'b1};
    @(posedge clk);
    bus.re <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One-shot modes clear the enable bit when they end
  task automatic wait_idle();
    logic [31:0] d;
    for (int i = 0; i < 500; i++) begin
      rd(ATC_REG_MODE0, d);
      if (d[ATC_M0_CE] === 1'b0) return;
    end
    err_total++;
    conclude();
  endtask
  task automatic wait_irqs(input int k);
    int got = 0;
    for (int i = 0; i < 2000 && got < k; i++) begin
      @(posedge clk);
      #1 if (irq === 1'b1) got++;
    end
    if (got < k) begin
      err_total++;
      conclude();
    end
  endtask
  task automatic run(input logic [1:0] md, input logic [4:0] ch, input logic [1:0] pf,
                     input logic [9:0] thr);
    wr(ATC_REG_STATUS, 32'h0000_0001);
    wr(ATC_REG_PFMODE, {30'h0, pf});
    wr(ATC_REG_PFTHR, {22'h0, thr});
    wr(ATC_REG_CHSEL, {27'h0, ch});
    wr(ATC_REG_MODE0, {28'h0, md, 2'h3});
  endtask
  function automatic logic exp_irq(logic [1:0] pf, logic [9:0] res, logic [9:0] thr);
    if (!pf[0]) return 1'b1;
    return pf[1] ? (res < thr) : (res == thr);
  endfunction
  // ==========================================================================
  // Main sequence
  initial begin
    logic [9:0] v, t;
    logic [4:0] ch;
    clk = 1'b0;
    sys_rst = 1'b1;
    trig = 1'b0;
    bus = '0;
    err_total = 0;
    n_checks = 0;
    v = 10'($urandom(5471));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) rchk(8'(i), 32'h0000_0000); // Index 5 is unmapped
    rchk(ATC_REG_RESBASE, 32'h0000_0000);
    chk({31'h0, power_down}, 32'h0000_0001);
    wr(ATC_REG_CHSEL, 32'h0000_001E);
    rchk(ATC_REG_CHSEL, 32'h0000_0017); // Too large a pick saturates
    $display("test reset done");
    // Every enable and condition against equal, lower and higher results, but k 7 wraps lower to 3FF, so enabled less-than sees no lower one
    for (int k = 0; k < 12; k++) begin
      ch = 5'($urandom % ATC_NUM_CH);
      t = (k == 7) ? 10'h000 : 10'(1 + $urandom % 1022);
      v = (k / 4 == 0) ? t : (k / 4 == 1) ? t - 10'h001 : t + 10'h001;
      i_front.level_q[ch] = v;
      run(ATC_MD_ONE_SEL, ch, 2'(k % 4), t);
      wait_idle();
      rchk(ATC_REG_STATUS, {31'h0, exp_irq(2'(k % 4), v, t)});
      rchk(8'(ATC_REG_RESBASE + ch), {22'h0, v});
    end
    $display("test compare done");
    // One-shot scan: only channel 0 decides
    for (int c = 0; c < 4; c++) i_front.level_q[c] = {2'(c), 8'($urandom)};
    for (int p = 0; p < 2; p++) begin
      run(ATC_MD_ONE_SCN, 5'h03, 2'h1, i_front.level_q[p * 3]);
      wait_idle();
      rchk(ATC_REG_STATUS, {31'h0, p == 0});
      for (int c = 0; c < 4; c++) rchk(8'(ATC_REG_RESBASE + c), {22'h0, i_front.level_q[c]});
    end
    $display("test scan done");
    // Continuous select, then a channel change with the flag up
    ch = 5'($urandom % ATC_NUM_CH);
    // Below full scale so the later less-than scan always fires
    i_front.level_q[ch] = 10'($urandom % 1023);
    run(ATC_MD_CONT_SEL, ch, 2'h0, 10'h000);
    // The first result after the scan is never trusted; read a later one
    wait_irqs(3);
    rchk(8'(ATC_REG_RESBASE + ch), {22'h0, i_front.level_q[ch]});
    wr(ATC_REG_CHSEL, {27'h0, 5'(ch ^ 5'h01)});
    rchk(ATC_REG_STATUS, 32'h0000_0001);
    wr(ATC_REG_MODE0, 32'h0000_0000);
    #1;
    chk({31'h0, power_down}, 32'h0000_0001);
    wr(ATC_REG_MODE0, 32'h0000_0002);
    #1;
    chk({31'h0, power_down}, 32'h0000_0000);
    $display("test continuous select done");
    // Hardware trigger mode: nothing starts until the pin rises
    i_front.level_q[5] = 10'($urandom);
    wr(ATC_REG_STATUS, 32'h0000_0001);
    wr(ATC_REG_PFMODE, 32'h0000_0000);
    wr(ATC_REG_CHSEL, 32'h0000_0005);
    wr(ATC_REG_MODE0, {27'h0, 1'b1, ATC_MD_ONE_SEL, 2'h3});
    repeat (20) @(posedge clk);
    rchk(ATC_REG_MODE0, 32'h0000_001B);
    trig <= 1'b1;
    wait_idle();
    trig <= 1'b0;
    rchk(ATC_REG_STATUS, 32'h0000_0001);
    rchk(8'(ATC_REG_RESBASE + 5), {22'h0, i_front.level_q[5]});
    $display("test hardware trigger done");
    // Continuous scan with a less-than verdict on channel 0
    run(ATC_MD_CONT_SCN, 5'h02, 2'h3, 10'h3FF);
    wait_irqs(2);
    wr(ATC_REG_MODE0, 32'h0000_0000);
    for (int c = 0; c < 3; c++) rchk(8'(ATC_REG_RESBASE + c), {22'h0, i_front.level_q[c]});
    wr(ATC_REG_STATUS, 32'h0000_0001);
    rchk(ATC_REG_STATUS, 32'h0000_0000);
    $display("test continuous scan done");
    conclude();
  end
endmodule // atc_ctrl_tb
